/* File: rtl/cp_cycle_timer.sv */
// Cycle counter pacing internal configuration register accesses
`timescale 1ns/10ps
module cp_cycle_timer
  import cp_xfer_pkg::*;
(
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic ce,
  input  wire logic start,
  output logic      busy,
  output logic      last
);

  logic [1:0] count_q;
  logic       busy_q;

  // Runs from start until the final cycle of the access
  always_ff @(posedge clock) begin
    if (!rstn) begin
      count_q <= 2'h0;
      busy_q  <= 1'b0;
    end else if (ce) begin
      if (start && !busy_q) begin
        busy_q  <= 1'b1;
        count_q <= 2'h0;
      end else if (busy_q && count_q == CFG_LAST) begin
        busy_q  <= 1'b0;
      end else if (busy_q) begin
        count_q <= count_q + 2'h1;
      end
    end
  end

  assign busy = busy_q;
  assign last = busy_q && (count_q == CFG_LAST);

endmodule : cp_cycle_timer

/* File: rtl/cp_decode.sv */
// Field decode and condition test for coprocessor transfer instructions
`timescale 1ns/10ps
module cp_decode
  import cp_xfer_pkg::*;
(
  input  wire logic [31:0]           instr,
  input  wire logic [3:0]            flags,
  output cp_xfer_pkg::decoded_s      dec,
  output logic                       cond_pass
);

  // Flag test for one condition code; N Z C V order in flags[3:0]
  function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
    logic n;
    logic z;
    logic cy;
    logic v;
    n  = f[3];
    z  = f[2];
    cy = f[1];
    v  = f[0];
    unique case (cond_e'(c))
      C_EQ: cond_ok = z;
      C_NE: cond_ok = !z;
      C_CS: cond_ok = cy;
      C_CC: cond_ok = !cy;
      C_MI: cond_ok = n;
      C_PL: cond_ok = !n;
      C_VS: cond_ok = v;
      C_VC: cond_ok = !v;
      C_HI: cond_ok = cy && !z;
      C_LS: cond_ok = !cy || z;
      C_GE: cond_ok = (n == v);
      C_LT: cond_ok = (n != v);
      C_GT: cond_ok = !z && (n == v);
      C_LE: cond_ok = z || (n != v);
      C_AL: cond_ok = 1'b1;
      C_NV: cond_ok = 1'b0;
    endcase
  endfunction : cond_ok

  // Class and field extraction
  always_comb begin
    dec.is_xfer  = (instr[CLASS_HI:CLASS_LO] == XFER_CLASS) && instr[XFER_MARK];
    dec.is_undef = (instr[CLASS_HI:RSV_LO] == UNDEF_CLASS) && instr[XFER_MARK];
    dec.cond     = instr[COND_HI:COND_LO];
    dec.to_cpu   = instr[DIR_BIT];
    dec.coproc_number_field              = instr[CPNUM_HI:CPNUM_LO];
    dec.coproc_operation_field           = instr[OPC_HI:OPC_LO];
    dec.coproc_secondary_operation_field = instr[SEC_HI:SEC_LO];
    dec.first_coproc_register_field      = instr[REG1_HI:REG1_LO];
    dec.second_coproc_register_field     = instr[REG2_HI:REG2_LO];
    dec.rd       = instr[RD_HI:RD_LO];
    cond_pass    = cond_ok(instr[COND_HI:COND_LO], flags);
  end

endmodule : cp_decode

/* File: rtl/cp_xfer.sv */
// Processor-side coprocessor register transfer and undefined trap control
// Operation
// - Non-15 transfers raise undefined-instruction trap
// - Failed condition means no effect at all
// - Coprocessor 15 transfers go to internal unit
// - Load word bits 31..28 into NZCV
// - Other bits dropped, PC unchanged
// - PC source supplies instruction address plus 12
// - Configuration register access takes 3 cycles
// - Other transfers emulated through the trap
// - Direction bit one means coprocessor to processor
// - Coprocessor number field selects target
// - Reserved encoding with true condition traps
`timescale 1ns/10ps
module cp_xfer
  import cp_xfer_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    rstn,
  input  wire logic                    ce,
  input  wire logic                    instr_valid,
  input  wire logic [31:0]             instr,
  input  wire logic [31:0]             instr_addr,
  input  wire logic [3:0]              flags_in,
  input  wire logic [31:0]             rd_value,
  input  wire logic [31:0]             ctrl_rdata,
  output logic                         instr_ready,
  output logic                         undef_trap,
  output cp_xfer_pkg::ctrl_req_s       ctrl_req,
  output logic                         ctrl_req_valid,
  output logic [31:0]                  ctrl_wdata,
  output logic                         reg_we,
  output logic [3:0]                   reg_addr,
  output logic [31:0]                  reg_wdata,
  output logic                         flags_we,
  output logic [3:0]                   flags_out
);

  typedef enum logic [1:0] {
    IDLE,
    ACCESS
  } state_e;

  state_e     state_q;
  decoded_s   dec;
  decoded_s   held_q;
  logic       cond_pass;
  logic       go;
  logic       is_ctrl;
  logic       tmr_last;
  logic [31:0] src_word;

  cp_decode u_decode (
    .instr     (instr),
    .flags     (flags_in),
    .dec       (dec),
    .cond_pass (cond_pass)
  );

  // Only executed instructions act; a false condition leaves no trace
  assign go      = ce && instr_valid && (state_q == IDLE) && cond_pass;
  assign is_ctrl = (dec.coproc_number_field == CTRL_COPROC);

  // PC as source reads ahead by the pipeline depth
  assign src_word = (dec.rd == PC_REG) ? instr_addr + PC_OFFSET : rd_value;

  // Accept new work only while idle; access holds the pipeline
  assign instr_ready = (state_q == IDLE);

  cp_cycle_timer u_timer (
    .clock (clock),
    .rstn  (rstn),
    .ce    (ce),
    .start (go && dec.is_xfer && is_ctrl),
    .busy  (),
    .last  (tmr_last)
  );

  // Sequencer for internal accesses
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_q <= IDLE;
    end else if (ce) begin
      unique case (state_q)
        IDLE: begin
          if (go && dec.is_xfer && is_ctrl) begin
            state_q <= ACCESS;
          end
        end
        ACCESS: begin
          if (tmr_last) begin
            state_q <= IDLE;
          end
        end
        default: state_q <= IDLE;
      endcase
    end
  end

  // Latched instruction while the internal access runs
  always_ff @(posedge clock) begin
    if (!rstn) begin
      held_q <= '0;
    end else if (go && dec.is_xfer && is_ctrl) begin
      held_q <= dec;
    end
  end

  // Trap pulse for foreign coprocessors and the reserved encoding
  always_ff @(posedge clock) begin
    if (!rstn) begin
      undef_trap <= 1'b0;
    end else if (ce) begin
      // Software emulation has no fixed timing, so only the entry is signalled
      undef_trap <= go && ((dec.is_xfer && !is_ctrl) || dec.is_undef);
    end
  end

  // Request to internal unit; field meaning is left to that unit
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctrl_req       <= '0;
      ctrl_req_valid <= 1'b0;
      ctrl_wdata     <= 32'h00000000;
    end else if (ce) begin
      if (go && dec.is_xfer && is_ctrl) begin
        ctrl_req_valid <= 1'b1;
        ctrl_req.write <= !dec.to_cpu;
        ctrl_req.opc   <= dec.coproc_operation_field;
        ctrl_req.sec   <= dec.coproc_secondary_operation_field;
        ctrl_req.reg1  <= dec.first_coproc_register_field;
        ctrl_req.reg2  <= dec.second_coproc_register_field;
        ctrl_wdata     <= dec.to_cpu ? 32'h00000000 : src_word;
      end else if (tmr_last) begin
        ctrl_req_valid <= 1'b0;
      end
    end
  end

  // Writeback at the final access cycle
  always_ff @(posedge clock) begin
    if (!rstn) begin
      reg_we    <= 1'b0;
      reg_addr  <= 4'h0;
      reg_wdata <= 32'h00000000;
      flags_we  <= 1'b0;
      flags_out <= 4'h0;
    end else if (ce) begin
      reg_we   <= 1'b0;
      flags_we <= 1'b0;
      if (tmr_last && held_q.to_cpu) begin
        if (held_q.rd == PC_REG) begin
          // Only the flags move; PC and the rest of the status word stay
          flags_we  <= 1'b1;
          flags_out <= ctrl_rdata[FLAG_HI:FLAG_LO];
        end else begin
          reg_we    <= 1'b1;
          reg_addr  <= held_q.rd;
          reg_wdata <= ctrl_rdata;
        end
      end
    end
  end

endmodule : cp_xfer

/* File: rtl/cp_xfer_pkg.sv */
// Shared constants and carriers for the coprocessor register transfer unit
package cp_xfer_pkg;

  // Instruction field positions
  localparam int COND_HI   = 31;
  localparam int COND_LO   = 28;
  localparam int CLASS_HI  = 27;
  localparam int CLASS_LO  = 24;
  localparam int RSV_LO    = 25;
  localparam int OPC_HI    = 23;
  localparam int OPC_LO    = 21;
  localparam int DIR_BIT   = 20;
  localparam int REG1_HI   = 19;
  localparam int REG1_LO   = 16;
  localparam int RD_HI     = 15;
  localparam int RD_LO     = 12;
  localparam int CPNUM_HI  = 11;
  localparam int CPNUM_LO  = 8;
  localparam int SEC_HI    = 7;
  localparam int SEC_LO    = 5;
  localparam int REG2_HI   = 3;
  localparam int REG2_LO   = 0;

  // Class patterns: register transfer bits 27:24 = 1110 with bit 4 = 1
  localparam logic [3:0] XFER_CLASS  = 4'hE;
  localparam int         XFER_MARK   = 4;
  // Reserved encoding: bits 27:25 = 011 with bit 4 = 1
  localparam logic [2:0] UNDEF_CLASS = 3'h3;

  localparam logic [3:0] CTRL_COPROC = 4'hF;
  localparam logic [3:0] PC_REG      = 4'hF;
  localparam logic [31:0] PC_OFFSET  = 32'h0000000C;

  // Configuration register access time in core cycles
  localparam int CFG_ACCESS_CYCLES = 3;
  localparam logic [1:0] CFG_LAST  = 2'(CFG_ACCESS_CYCLES - 1);

  // Flag positions inside the status register and transferred word
  localparam int FLAG_HI = 31;
  localparam int FLAG_LO = 28;

  // Condition codes
  typedef enum logic [3:0] {
    C_EQ = 4'h0, C_NE = 4'h1, C_CS = 4'h2, C_CC = 4'h3,
    C_MI = 4'h4, C_PL = 4'h5, C_VS = 4'h6, C_VC = 4'h7,
    C_HI = 4'h8, C_LS = 4'h9, C_GE = 4'hA, C_LT = 4'hB,
    C_GT = 4'hC, C_LE = 4'hD, C_AL = 4'hE, C_NV = 4'hF
  } cond_e;

  // Decoded instruction carrier
  typedef struct packed {
    logic       is_xfer;
    logic       is_undef;
    logic [3:0] cond;
    logic       to_cpu;
    logic [3:0] coproc_number_field;
    logic [2:0] coproc_operation_field;
    logic [2:0] coproc_secondary_operation_field;
    logic [3:0] first_coproc_register_field;
    logic [3:0] second_coproc_register_field;
    logic [3:0] rd;
  } decoded_s;

  // Request to the internal control coprocessor
  typedef struct packed {
    logic       write;
    logic [2:0] opc;
    logic [2:0] sec;
    logic [3:0] reg1;
    logic [3:0] reg2;
  } ctrl_req_s;

endpackage : cp_xfer_pkg

/* File: testbench/cp_xfer_checker.sv */
// Concurrent checks on the transfer unit ports
`timescale 1ns/10ps
module cp_xfer_checker
  import cp_xfer_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                rstn,
  input  wire logic                ce,
  input  wire logic                instr_valid,
  input  wire logic [31:0]         instr,
  input  wire logic [31:0]         instr_addr,
  input  wire logic                instr_ready,
  input  wire logic                undef_trap,
  input  cp_xfer_pkg::ctrl_req_s   ctrl_req,
  input  wire logic                ctrl_req_valid,
  input  wire logic [31:0]         ctrl_wdata,
  input  wire logic [31:0]         ctrl_rdata,
  input  wire logic                reg_we,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                flags_we,
  input  wire logic [3:0]          flags_out
);
  logic offer;
  logic take;

  default clocking cb @(posedge clock); endclocking
  // A stalled edge freezes the unit, so counted checks spanning it are abandoned
  default disable iff (!rstn || !ce);

  // Always-true transfers only, so no flag decode is needed here
  assign offer = ce && instr_valid && instr_ready;
  assign take  = offer && instr[27:24] == XFER_CLASS && instr[4] && instr[31:28] == C_AL;

  a_trap_foreign: assert property (take && instr[11:8] != CTRL_COPROC |=> undef_trap)
    else $error("foreign coprocessor did not trap");
  a_trap_reserved: assert property (
    offer && instr[27:25] == UNDEF_CLASS && instr[4] && instr[31:28] == C_AL |=> undef_trap)
    else $error("reserved word did not trap");
  a_never_cond: assert property (
    offer && instr[31:28] == C_NV |=> !undef_trap && !ctrl_req_valid)
    else $error("never condition had effect");
  a_route_ctrl: assert property (
    take && instr[11:8] == CTRL_COPROC |=> ctrl_req_valid && !undef_trap)
    else $error("control access not started");
  a_cfg_three: assert property (
    $rose(ctrl_req_valid) |-> (ctrl_req_valid && !instr_ready)[*3] ##1 !ctrl_req_valid)
    else $error("access length wrong");
  a_dir_bit: assert property (
    $rose(ctrl_req_valid) |-> ctrl_req.write == !$past(instr[DIR_BIT]))
    else $error("direction wrong");
  a_req_fields: assert property (
    $rose(ctrl_req_valid) |-> {ctrl_req.opc, ctrl_req.sec, ctrl_req.reg1, ctrl_req.reg2}
    == {$past(instr[23:21]), $past(instr[7:5]), $past(instr[19:16]), $past(instr[3:0])})
    else $error("request fields wrong");
  a_pc_source: assert property (
    $rose(ctrl_req_valid) && ctrl_req.write && $past(instr[15:12]) == PC_REG
    |-> ctrl_wdata == $past(instr_addr) + PC_OFFSET)
    else $error("pc source value wrong");
  a_read_word: assert property (reg_we |-> reg_wdata == $past(ctrl_rdata))
    else $error("read word wrong");
  a_flag_copy: assert property (
    flags_we |-> !reg_we && flags_out == $past(ctrl_rdata[FLAG_HI:FLAG_LO]))
    else $error("flag copy wrong");
endmodule : cp_xfer_checker

/* File: testbench/ctrl_cp_model.sv */
// Behavioural model of the internal control coprocessor
`timescale 1ns/10ps
module ctrl_cp_model
  import cp_xfer_pkg::*;
(
  input  wire logic                clock,
  input  cp_xfer_pkg::ctrl_req_s   ctrl_req,
  input  wire logic                ctrl_req_valid,
  output logic [31:0]              ctrl_rdata
);
  logic [31:0] junk = 32'h3C3C3C3C;

  // Idle read bus toggles so stale data never looks valid
  always_ff @(posedge clock) begin
    junk <= ~junk;
  end

  // Read word built from the register fields only
  assign ctrl_rdata = ctrl_req_valid ? {ctrl_req.reg1, ctrl_req.reg2, 24'h5A5A5A} : junk;
endmodule : ctrl_cp_model

/* File: testbench/tb_top.sv */
// Self-checking bench for the coprocessor transfer unit
`timescale 1ns/10ps
module tb_top;
  import cp_xfer_pkg::*;
  logic        clock = 0, rstn = 0, instr_valid = 0, pv = 0, ce = 1;
  logic [31:0] instr = 0, instr_addr = 0, rd_value = 0, seed = 32'h0016;
  logic [3:0]  flags_in = 0, reg_addr, flags_out;
  ctrl_req_s   ctrl_req;
  logic [31:0] ctrl_rdata, ctrl_wdata, reg_wdata;
  logic        instr_ready, undef_trap, ctrl_req_valid, reg_we, flags_we;
  logic [37:0] q[$];
  int          n_mismatch = 0, compares = 0;

  cp_xfer dut (.clock, .rstn, .ce, .instr_valid, .instr, .instr_addr, .flags_in,
    .rd_value, .ctrl_rdata, .instr_ready, .undef_trap, .ctrl_req, .ctrl_req_valid,
    .ctrl_wdata, .reg_we, .reg_addr, .reg_wdata, .flags_we, .flags_out);
  ctrl_cp_model far (.clock, .ctrl_req, .ctrl_req_valid, .ctrl_rdata);

  // 20 MHz core clock
  initial forever #25 clock = ~clock;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // Flags are N Z C V, msb first
  function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
    logic b;
    case (c[3:1])
      3'h0: b = f[2];
      3'h1: b = f[1];
      3'h2: b = f[3];
      3'h3: b = f[0];
      3'h4: b = f[1] & ~f[2];
      3'h5: b = f[3] == f[0];
      3'h6: b = ~f[2] & (f[3] == f[0]);
      default: return c == C_AL;
    endcase
    return b ^ c[0];
  endfunction : cond_ok

  task automatic stop_test();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task automatic cmp(input logic [37:0] got);
    compares++;
    if (q.size() == 0 || q[0] !== got) begin
      n_mismatch++;
      $display("CHECK FAILED %0t unexpected result %h", $time, got);
    end
    if (q.size() > 0) void'(q.pop_front());
  endtask : cmp

  // One compare per result kind, each against the oldest note
  task automatic cmp_trap();
    cmp({2'h0, 36'h0});
  endtask : cmp_trap

  task automatic cmp_reg(input logic [3:0] a, input logic [31:0] v);
    cmp({2'h1, a, v});
  endtask : cmp_reg

  task automatic cmp_flags(input logic [3:0] f);
    cmp({2'h2, 32'h0, f});
  endtask : cmp_flags

  task automatic cmp_write(input logic [31:0] v);
    cmp({2'h3, 4'h0, v});
  endtask : cmp_write

  // Present one word once idle and note what it must produce
  task automatic issue(input logic [31:0] w);
    int n;
    logic [31:0] d;
    n = 0;
    @(negedge clock);
    while (instr_ready !== 1'b1 && n < 40) begin
      n++;
      // Random stalls only inside an access, so every result pulse ends on a live edge
      ce = (xs() & 32'h3) != 32'h0;
      @(negedge clock);
    end
    if (instr_ready !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED %0t instruction never accepted", $time);
      stop_test();
    end else begin
      ce = 1;
      d = xs();
      instr_valid = 1;
      instr = w;
      instr_addr = {d[31:2], 2'h0};
      flags_in = d[3:0];
      rd_value = xs();
      d = {w[19:16], w[3:0], 24'h5A5A5A};
      if (cond_ok(w[31:28], flags_in)) begin
        if (w[27:25] == UNDEF_CLASS || w[11:8] != CTRL_COPROC) q.push_back({2'h0, 36'h0});
        else if (w[DIR_BIT] && w[15:12] == PC_REG) q.push_back({2'h2, 32'h0, d[31:28]});
        else if (w[DIR_BIT]) q.push_back({2'h1, w[15:12], d});
        else q.push_back({2'h3, 4'h0, w[15:12] == PC_REG ? instr_addr + PC_OFFSET : rd_value});
      end
      @(posedge clock);
    end
  endtask : issue

  // Result watcher, looks once the edge has settled
  always @(posedge clock) begin
    #1;
    if (undef_trap === 1'b1) cmp_trap();
    if (reg_we === 1'b1) cmp_reg(reg_addr, reg_wdata);
    if (flags_we === 1'b1) cmp_flags(flags_out);
    if (ctrl_req_valid === 1'b1 && pv !== 1'b1 && ctrl_req.write === 1'b1)
      cmp_write(ctrl_wdata);
    pv = ctrl_req_valid;
  end

  // Reserved words under every condition, then mixed transfers back to back
  initial begin
    int i;
    logic [31:0] r;
    repeat (3) @(negedge clock);
    rstn = 1;
    for (i = 0; i < 64; i++) begin
      r = xs();
      if (i < 16) issue({4'(i), 3'h3, r[24:5], 1'b1, r[3:0]});
      else issue({i < 32 ? r[31:28] : 4'hE, 4'hE, r[23:16], i[2] ? 4'hF : r[15:12],
        i[0] ? 4'hF : 4'(i >> 1), r[7:5], 1'b1, r[3:0]});
    end
    @(negedge clock);
    instr_valid = 0;
    repeat (8) @(negedge clock);
    if (q.size() != 0) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %0d results missing", $time, q.size());
    end
    stop_test();
  end
endmodule : tb_top

bind cp_xfer cp_xfer_checker chk (.clock, .rstn, .ce, .instr_valid, .instr, .instr_addr,
  .instr_ready, .undef_trap, .ctrl_req, .ctrl_req_valid, .ctrl_wdata, .ctrl_rdata,
  .reg_we, .reg_wdata, .flags_we, .flags_out);
